// ==== shared/local_mem_pkg.sv ====
// Constants and types shared by the local memory rate control block
package local_mem_pkg;
	// Summary of operation
	// - Memories are four blocks of 4x64 locations.
	// - Rows map to 16 streams, columns to slots.
	// - Host gives stream and slot; device maps addresses.
	// - One placement scheme fills every memory.
	// - C fast, A slowest: extra virtual 4x64 space.
	// - Parallel data forms one sequential slot stream.
	// - Parallel scan: all, even, or every second even.
	// - Bits 7-6 select the conversion mode.
	// - Rate fields: off, 2.048, 4.096, 8.192 Mbit/s.
	// - Serial mode: one rate per group, both directions.
	// - B needs A not fastest; C needs B not fastest.
	// - Serial-in parallel-out: A input rate, C output.
	// - Parallel-in modes: A input, B reserved, C output.
	// - Host reads memories indirectly by stream and slot.
	// - State counter sequences all, aligned to frame.
	// - Counter is modulo 8192: slot, stream, function.
	// - Diagnostics may reset or load the counter.
	// - Frame follows the backplane or the trunks.
	// - Backplane memories share the same state counter.
	// - Group A lines 0-7, B 8-11, C 12-15.
	// - Scan A, B, C; slower repeat transfers ignored.
	// - Parallel uses lines 0-7 only, no serial streaming.
	// - Unassigned output slots float to high impedance.

	// Internal 65.536 MHz clock made from SYS_CLK by phase accumulation, in kHz
	localparam logic [17:0] SYS_CLK_KHZ = 18'h30D40;
	localparam logic [17:0] INT_CLK_KHZ = 18'h10000;
	localparam logic [17:0] PHASE_RESET = 18'h00000;

	localparam int MEM_WORDS = 1024;
	localparam logic [12:0] CNT_RESET = 13'h0000;
	localparam logic [12:0] FRAME_LAST = 13'h1FFF;

	// Register byte offsets
	localparam logic [7:0] OFS_MEM_ADDR = 8'h00;
	localparam logic [7:0] OFS_MEM_CTRL = 8'h04;
	localparam logic [7:0] OFS_MEM_DATA = 8'h08;
	localparam logic [7:0] OFS_LOCAL_STREAM_CONFIG = 8'h0C;
	localparam logic [7:0] OFS_DIAG_CTRL = 8'h10;
	localparam logic [7:0] OFS_DIAG_LOAD = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;

	// Field positions and reset values
	localparam logic [7:0] LSC_RESET = 8'h00;
	localparam int MC_TARGET = 0;
	localparam int MC_WRITE = 1;
	localparam int MC_BANK = 2;
	localparam int DG_RESET = 0;
	localparam int DG_LOAD = 1;
	localparam int DG_FRSEL = 2;
	localparam int CONN_VALID = 11;
	localparam int CONN_DELAY = 10;
	localparam logic [3:0] GRP_B_FIRST = 4'h8;
	localparam logic [3:0] GRP_C_FIRST = 4'hC;

	typedef enum logic [1:0] {MODE_SS = 2'h0, MODE_SP = 2'h1, MODE_PS = 2'h2, MODE_PP = 2'h3} conv_mode_t;
	typedef enum logic [1:0] {RATE_OFF = 2'h0, RATE_2M = 2'h1, RATE_4M = 2'h2, RATE_8M = 2'h3} rate_t;
	typedef enum logic [1:0] {FN_INPUT = 2'h0, FN_CONN = 2'h1, FN_OUTPUT = 2'h2, FN_HOST = 2'h3} func_t;
endpackage

// ==== shared/map_if.sv ====
// Request and answer of one stream and slot to memory address mapping
interface map_if;
	import local_mem_pkg::*;
	logic par;
	logic scan;
	rate_t rate;
	logic [7:0] cfg;
	logic [3:0] stream;
	logic [6:0] slot;
	logic [9:0] addr;
	logic ok;
	modport client(output par, scan, rate, cfg, stream, slot, input addr, ok);
	modport mapper(input par, scan, rate, cfg, stream, slot, output addr, ok);
endinterface

// ==== verilog/slot_mapper.sv ====
// Maps a stream and time slot onto a physical local memory location
module slot_mapper
	import local_mem_pkg::*;
(
	map_if.mapper m
);
	wire logic [6:0] lslot;
	wire logic [9:0] pidx;
	wire logic [1:0] low2;
	wire logic [1:0] grp;
	wire logic [1:0] blk;
	wire logic [5:0] col;
	wire logic rate_go;
	wire logic in_range;
	wire logic hi;
	wire logic virt;
	wire logic virt_ok;
	wire logic ser_ok;
	wire logic par_ok;

	// Parallel data is one stream of sequential slots
	assign pidx = {m.slot, m.stream[2:0]};
	assign low2 = m.par ? pidx[1:0] : m.slot[1:0];
	assign rate_go = (m.rate == RATE_8M) | (m.rate == RATE_4M & ~low2[0]) | (m.rate == RATE_2M & low2 == 2'h0);

	// Scan slots are in fastest-rate units, host slots are already logical
	assign lslot = (!m.scan || m.rate == RATE_8M) ? m.slot :
		((m.rate == RATE_4M) ? {1'h0, m.slot[6:1]} : {2'h0, m.slot[6:2]});
	assign in_range = m.scan | m.rate == RATE_8M | (m.rate == RATE_4M & ~lslot[6]) | (lslot[6:5] == 2'h0);

	// Upper 64 slots fold into blocks idle at that rate setting
	assign hi = lslot[6];
	assign grp = m.stream[3:2];
	assign virt = hi & grp == 2'h3;
	assign virt_ok = m.cfg[5:4] == RATE_2M & m.cfg[3:2] != RATE_8M;
	assign blk = ~hi ? grp : (~grp[1] ? {1'h1, grp[0]} : ((grp == 2'h2) ? 2'h3 : {1'h0, lslot[5]}));
	assign col = virt ? {1'h1, lslot[4:0]} : lslot[5:0];
	assign ser_ok = m.rate != RATE_OFF & (m.scan ? rate_go : in_range) & (~virt | virt_ok);
	assign par_ok = ~m.stream[3] & (m.scan ? rate_go : m.rate != RATE_OFF);
	assign m.addr = m.par ? pidx : {blk, m.stream[1:0], col};
	assign m.ok = m.par ? par_ok : ser_ok;
endmodule

// ==== verilog/local_rate_ctrl.sv ====
// Local memory rate control: register slave, state counter and stream datapath
module local_rate_ctrl
	import local_mem_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	input wire logic CLK_EN,
	input wire logic [7:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic BUS_FRAME,
	input wire logic TRUNK_FRAME,
	input wire logic [7:0] LIN_DATA,
	output logic [7:0] LOUT_DATA,
	output logic LOUT_OE,
	output logic [3:0] LOUT_STREAM,
	output logic [12:0] STATE_COUNT
);
	// ****************************************
	// Declarations
	// ****************************************
	logic wait_q;
	logic [31:0] readdata_q;
	logic [6:0] slot_q;
	logic [3:0] strm_q;
	logic [2:0] mctl_q;
	logic busy_q;
	logic err_q;
	logic [11:0] wdata_q;
	logic [11:0] rdata_q;
	logic [7:0] lsc_q;
	logic frsel_q;
	logic [12:0] load_q;
	logic [1:0] fr_s1_q;
	logic [1:0] fr_s2_q;
	logic fr_prev_q;
	logic [17:0] ph_q;
	logic [12:0] cnt_q;
	logic bank_q;
	logic [11:0] conn_q;
	logic oen_q;
	logic [7:0] lout_q;
	logic oe_q;
	logic [3:0] lstrm_q;
	logic [11:0] cmem [MEM_WORDS];
	logic [7:0] dmem [2][MEM_WORDS];

	// ****************************************
	// Bus decode
	// ****************************************
	wire logic rw_req;
	wire logic wr_go;
	wire logic hit_maddr;
	wire logic hit_mctl;
	wire logic hit_mdata;
	wire logic hit_lsc;
	wire logic hit_dctl;
	wire logic hit_dload;
	wire logic hit_status;
	wire logic diag_rst;
	wire logic diag_load;
	wire logic [31:0] rd_word;

	assign rw_req = AVS_READ | AVS_WRITE;
	// A write lands on the edge where the master sees waitrequest low
	assign wr_go = AVS_WRITE & ~wait_q;
	assign hit_maddr = AVS_ADDRESS == OFS_MEM_ADDR;
	assign hit_mctl = AVS_ADDRESS == OFS_MEM_CTRL;
	assign hit_mdata = AVS_ADDRESS == OFS_MEM_DATA;
	assign hit_lsc = AVS_ADDRESS == OFS_LOCAL_STREAM_CONFIG;
	assign hit_dctl = AVS_ADDRESS == OFS_DIAG_CTRL;
	assign hit_dload = AVS_ADDRESS == OFS_DIAG_LOAD;
	assign hit_status = AVS_ADDRESS == OFS_STATUS;
	assign diag_rst = wr_go & hit_dctl & AVS_BYTEENABLE[0] & AVS_WRITEDATA[DG_RESET];
	assign diag_load = wr_go & hit_dctl & AVS_BYTEENABLE[0] & AVS_WRITEDATA[DG_LOAD];

	assign rd_word = hit_maddr ? {20'h00000, strm_q, 1'h0, slot_q} :
		hit_mctl ? {24'h000000, busy_q, err_q, 3'h0, mctl_q} :
		hit_mdata ? {20'h00000, rdata_q} :
		hit_lsc ? {24'h000000, lsc_q} :
		hit_dctl ? {29'h00000000, frsel_q, 2'h0} :
		hit_dload ? {19'h00000, load_q} :
		hit_status ? {17'h00000, busy_q, bank_q, cnt_q} : 32'h00000000;

	// ****************************************
	// Frame source and internal clock tick
	// ****************************************
	wire logic frame_sel;
	wire logic frame_rise;
	wire logic [18:0] ph_sum;
	wire logic tick;
	wire logic step;

	assign frame_sel = frsel_q ? fr_s2_q[1] : fr_s2_q[0];
	assign frame_rise = frame_sel & ~fr_prev_q;
	assign ph_sum = {1'h0, ph_q} + {1'h0, INT_CLK_KHZ};
	assign tick = ph_sum >= {1'h0, SYS_CLK_KHZ};
	assign step = tick & ~diag_rst & ~diag_load & ~frame_rise;

	// ****************************************
	// Mode and rate resolution
	// ****************************************
	conv_mode_t mode;
	rate_t ra;
	rate_t rb;
	rate_t rc;
	rate_t rc_raw;
	func_t fn;
	wire logic par_in;
	wire logic par_out;
	wire logic [3:0] sc_stream;
	wire logic [6:0] sc_slot;

	assign mode = conv_mode_t'(lsc_q[7:6]);
	assign ra = rate_t'(lsc_q[5:4]);
	assign rc_raw = rate_t'(lsc_q[1:0]);
	assign rb = (ra != RATE_8M) ? rate_t'(lsc_q[3:2]) : RATE_OFF;
	assign rc = (rate_t'(lsc_q[3:2]) != RATE_8M) ? rc_raw : RATE_OFF;
	assign par_in = mode == MODE_PS || mode == MODE_PP;
	assign par_out = mode == MODE_SP || mode == MODE_PP;
	assign fn = func_t'(cnt_q[1:0]);
	assign sc_stream = cnt_q[5:2];
	assign sc_slot = cnt_q[12:6];

	// Rate that applies to one stream on its input or output side
	function automatic rate_t side_rate(input logic [3:0] s, input logic out_side, input conv_mode_t md, input rate_t a,
		input rate_t b, input rate_t c, input rate_t c_raw);
		rate_t grp;
		rate_t res;
		grp = (s < GRP_B_FIRST) ? a : ((s < GRP_C_FIRST) ? b : c);
		if (md == MODE_SS) begin
			res = grp;
		end else if (s[3]) begin
			res = RATE_OFF;
		end else if (out_side) begin
			res = c_raw;
		end else begin
			res = a;
		end
		return res;
	endfunction

	// ****************************************
	// Address mappers
	// ****************************************
	map_if in_m ();
	map_if out_m ();
	map_if host_m ();

	assign in_m.par = par_in;
	assign in_m.scan = 1'h1;
	assign in_m.rate = side_rate(sc_stream, 1'h0, mode, ra, rb, rc, rc_raw);
	assign in_m.cfg = lsc_q;
	assign in_m.stream = sc_stream;
	assign in_m.slot = sc_slot;

	assign out_m.par = par_out;
	assign out_m.scan = 1'h1;
	assign out_m.rate = side_rate(sc_stream, 1'h1, mode, ra, rb, rc, rc_raw);
	assign out_m.cfg = lsc_q;
	assign out_m.stream = sc_stream;
	assign out_m.slot = sc_slot;

	// Data memory is placed by input side, connection memory by output side
	assign host_m.par = mctl_q[MC_TARGET] ? par_in : par_out;
	assign host_m.scan = 1'h0;
	assign host_m.rate = side_rate(strm_q, ~mctl_q[MC_TARGET], mode, ra, rb, rc, rc_raw);
	assign host_m.cfg = lsc_q;
	assign host_m.stream = strm_q;
	assign host_m.slot = slot_q;

	slot_mapper u_in_map (
		.m(in_m)
	);
	slot_mapper u_out_map (
		.m(out_m)
	);
	slot_mapper u_host_map (
		.m(host_m)
	);

	// ****************************************
	// Memory write steering
	// ****************************************
	wire logic host_slot;
	wire logic host_wr;
	wire logic dm_we;
	wire logic dm_bank;
	wire logic [9:0] dm_addr;
	wire logic [7:0] dm_wdata;
	wire logic cm_we;
	wire logic rd_bank;

	assign host_slot = step & fn == FN_HOST & busy_q & host_m.ok;
	assign host_wr = host_slot & mctl_q[MC_WRITE];
	assign dm_we = (step & fn == FN_INPUT & in_m.ok) | (host_wr & mctl_q[MC_TARGET]);
	assign dm_bank = (fn == FN_INPUT) ? bank_q : mctl_q[MC_BANK];
	assign dm_addr = (fn == FN_INPUT) ? in_m.addr : host_m.addr;
	assign dm_wdata = (fn == FN_INPUT) ? LIN_DATA : wdata_q[7:0];
	assign cm_we = host_wr & ~mctl_q[MC_TARGET];
	// Constant delay reads the bank filled during the previous frame
	assign rd_bank = conn_q[CONN_DELAY] ? ~bank_q : bank_q;

	// ****************************************
	// Bus slave and registers
	// ****************************************
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wait_q <= 1'h1;
			readdata_q <= 32'h00000000;
		end else if (CLK_EN) begin
			wait_q <= ~(rw_req & wait_q);
			if (AVS_READ && wait_q) begin
				readdata_q <= rd_word;
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			slot_q <= 7'h00;
			strm_q <= 4'h0;
			mctl_q <= 3'h0;
			wdata_q <= 12'h000;
			lsc_q <= LSC_RESET;
			frsel_q <= 1'h0;
			load_q <= CNT_RESET;
		end else if (CLK_EN && wr_go) begin
			if (hit_maddr && AVS_BYTEENABLE[0]) begin
				slot_q <= AVS_WRITEDATA[6:0];
			end
			if (hit_maddr && AVS_BYTEENABLE[1]) begin
				strm_q <= AVS_WRITEDATA[11:8];
			end
			if (hit_mctl && AVS_BYTEENABLE[0] && !busy_q) begin
				mctl_q <= AVS_WRITEDATA[2:0];
			end
			if (hit_mdata && AVS_BYTEENABLE[0]) begin
				wdata_q[7:0] <= AVS_WRITEDATA[7:0];
			end
			if (hit_mdata && AVS_BYTEENABLE[1]) begin
				wdata_q[11:8] <= AVS_WRITEDATA[11:8];
			end
			if (hit_lsc && AVS_BYTEENABLE[0]) begin
				lsc_q <= AVS_WRITEDATA[7:0];
			end
			if (hit_dctl && AVS_BYTEENABLE[0]) begin
				frsel_q <= AVS_WRITEDATA[DG_FRSEL];
			end
			if (hit_dload && AVS_BYTEENABLE[0]) begin
				load_q[7:0] <= AVS_WRITEDATA[7:0];
			end
			if (hit_dload && AVS_BYTEENABLE[1]) begin
				load_q[12:8] <= AVS_WRITEDATA[12:8];
			end
		end
	end

	// ****************************************
	// Indirect host access
	// ****************************************
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			busy_q <= 1'h0;
			err_q <= 1'h0;
			rdata_q <= 12'h000;
		end else if (CLK_EN) begin
			if (wr_go && hit_mctl && AVS_BYTEENABLE[0] && !busy_q) begin
				busy_q <= 1'h1;
			end else if (step && fn == FN_HOST && busy_q) begin
				busy_q <= 1'h0;
				err_q <= ~host_m.ok;
				if (!mctl_q[MC_WRITE]) begin
					rdata_q <= !host_m.ok ? 12'h000 : (mctl_q[MC_TARGET] ?
						{4'h0, dmem[mctl_q[MC_BANK]][host_m.addr]} : cmem[host_m.addr]);
				end
			end
		end
	end

	// ****************************************
	// Frame synchroniser, tick and state counter
	// ****************************************
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			fr_s1_q <= 2'h0;
			fr_s2_q <= 2'h0;
			fr_prev_q <= 1'h0;
			ph_q <= PHASE_RESET;
		end else if (CLK_EN) begin
			fr_s1_q <= {TRUNK_FRAME, BUS_FRAME};
			fr_s2_q <= fr_s1_q;
			fr_prev_q <= frame_sel;
			ph_q <= tick ? 18'(ph_sum - {1'h0, SYS_CLK_KHZ}) : ph_sum[17:0];
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cnt_q <= CNT_RESET;
			bank_q <= 1'h0;
		end else if (CLK_EN) begin
			if (diag_rst) begin
				cnt_q <= CNT_RESET;
			end else if (diag_load) begin
				cnt_q <= load_q;
			end else if (frame_rise) begin
				cnt_q <= CNT_RESET;
				if (cnt_q != CNT_RESET) begin
					bank_q <= ~bank_q;
				end
			end else if (tick) begin
				cnt_q <= cnt_q + 13'h0001;
				if (cnt_q == FRAME_LAST) begin
					bank_q <= ~bank_q;
				end
			end
		end
	end

	// ****************************************
	// Memories
	// ****************************************
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			for (int i = 0; i < MEM_WORDS; i++) begin
				cmem[i] <= 12'h000;
			end
		end else if (CLK_EN && cm_we) begin
			cmem[host_m.addr] <= wdata_q;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (CLK_EN && dm_we) begin
			dmem[dm_bank][dm_addr] <= dm_wdata;
		end
	end

	// ****************************************
	// Output slot pipeline
	// ****************************************
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			conn_q <= 12'h000;
			oen_q <= 1'h0;
			lout_q <= 8'h00;
			oe_q <= 1'h0;
			lstrm_q <= 4'h0;
		end else if (CLK_EN && step) begin
			unique case (fn)
				FN_INPUT: begin
					oen_q <= oen_q;
				end
				FN_CONN: begin
					conn_q <= cmem[out_m.addr];
					oen_q <= out_m.ok;
				end
				FN_OUTPUT: begin
					lout_q <= dmem[rd_bank][conn_q[9:0]];
					oe_q <= oen_q & conn_q[CONN_VALID];
					lstrm_q <= sc_stream;
				end
				FN_HOST: begin
					oen_q <= oen_q;
				end
			endcase
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign AVS_READDATA = readdata_q;
	assign AVS_WAITREQUEST = wait_q;
	assign LOUT_DATA = lout_q;
	assign LOUT_OE = oe_q;
	assign LOUT_STREAM = lstrm_q;
	assign STATE_COUNT = cnt_q;
endmodule

// ==== dv/local_rate_ctrl_properties.sv ====
// Port checker for the local rate control block
module local_rate_ctrl_properties
	import local_mem_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	input wire logic CLK_EN,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	input wire logic LOUT_OE,
	input wire logic [3:0] LOUT_STREAM,
	input wire logic [12:0] STATE_COUNT
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RESET_N);
	wire req = AVS_READ || AVS_WRITE;
	// *****
	// Register bus
	// *****
	a_wait_pulse: assert property (!AVS_WAITREQUEST && CLK_EN |=> AVS_WAITREQUEST)
		else $error("waitrequest low for more than one cycle");
	a_wait_answer: assert property (req && AVS_WAITREQUEST && CLK_EN |=> !AVS_WAITREQUEST)
		else $error("request not answered in one cycle");
	a_wait_cause: assert property ($fell(AVS_WAITREQUEST) |-> $past(req))
		else $error("answer without a request");
	a_rdata_hold: assert property ($changed(AVS_READDATA) |-> !AVS_WAITREQUEST && $past(AVS_READ))
		else $error("read data changed outside a read");
	// *****
	// State counter and output pipeline
	// *****
	a_count_step: assert property ($changed(STATE_COUNT) |->
		STATE_COUNT == $past(STATE_COUNT) + 13'h1 || STATE_COUNT == 13'h0 || $past(AVS_WAITREQUEST) == 1'b0)
		else $error("state counter jumped");
	a_count_frozen: assert property (!CLK_EN |=> $stable(STATE_COUNT) && $stable(AVS_WAITREQUEST))
		else $error("state moved while clock enable low");
	a_tick_alive: assert property (CLK_EN [*4] |=> STATE_COUNT != $past(STATE_COUNT, 4))
		else $error("state counter stalled");
	a_lout_phase: assert property ($changed(LOUT_STREAM) || $changed(LOUT_OE) |->
		$past(STATE_COUNT[1:0]) == FN_OUTPUT)
		else $error("output changed outside output function");
	a_lout_stream: assert property ($changed(LOUT_STREAM) |-> LOUT_STREAM == $past(STATE_COUNT[5:2]))
		else $error("output stream differs from counter stream");
	c_read: cover property (!AVS_WAITREQUEST && AVS_READ);
	c_wrap: cover property ($past(STATE_COUNT) == FRAME_LAST && STATE_COUNT == 13'h0);
	c_drive: cover property ($rose(LOUT_OE));
endmodule

bind local_rate_ctrl local_rate_ctrl_properties chk (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
	.LOUT_OE(LOUT_OE), .LOUT_STREAM(LOUT_STREAM), .STATE_COUNT(STATE_COUNT));

// ==== dv/stream_partner.sv ====
// Far-side model of the local stream lines
module stream_partner (
	input wire logic clk,
	input wire logic [12:0] count,
	input wire logic [7:0] out_data,
	input wire logic out_oe,
	input wire logic [3:0] out_stream,
	output logic [7:0] in_data,
	output logic [7:0] line,
	output logic [7:0] seen,
	output int others
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] held = 8'h00;
	initial begin
		in_data = 8'h00;
		seen = 8'h00;
		others = 0;
	end
	// A released line shows the inverse of its last driven byte
	assign line = out_oe ? out_data : ~held;
	always @(posedge clk) begin
		in_data <= {4'hA, count[5:2]};
		if (out_oe) begin
			held <= out_data;
		end
		if (out_oe && out_stream == 4'h2) begin
			seen <= line;
		end
		if (out_oe && out_stream != 4'h2) begin
			others <= others + 1;
		end
	end
endmodule

// ==== dv/local_rate_ctrl_tb_top.sv ====
// Self-checking testbench for the local rate control block
module local_rate_ctrl_tb_top
	import local_mem_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic clk_en = 1'b1;
	logic en_rand = 1'b0;
	logic [7:0] address = 8'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic bus_frame = 1'b0;
	logic trunk_frame = 1'b0;
	logic [31:0] rdata, q, v;
	logic waitreq, oe;
	logic [7:0] lin, lout, line, seen;
	logic [3:0] lstream;
	logic [12:0] count;
	int others;
	int bad_count = 0;
	int n_compared = 0;
	int cycles = 0;

	always #2.5 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		clk_en <= !en_rand || ($urandom_range(7) != 0);
		if (cycles == 60000) begin
			bad_count++;
			stop_test();
		end
	end

	local_rate_ctrl DUT (.SYS_CLK(sys_clk), .RESET_N(reset_n), .CLK_EN(clk_en), .AVS_ADDRESS(address),
		.AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(waitreq), .BUS_FRAME(bus_frame), .TRUNK_FRAME(trunk_frame), .LIN_DATA(lin),
		.LOUT_DATA(lout), .LOUT_OE(oe), .LOUT_STREAM(lstream), .STATE_COUNT(count));

	stream_partner far_side (.clk(sys_clk), .count(count), .out_data(lout), .out_oe(oe), .out_stream(lstream),
		.in_data(lin), .line(line), .seen(seen), .others(others));

	// *****
	// Helpers
	// *****
	task automatic stop_test();
		if (bad_count == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One Avalon access; read data lands in q
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		address <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge sys_clk);
			n++;
		end while ((waitreq !== 1'b0 || clk_en !== 1'b1) && n < 200);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 200) begin
			bad_count++;
			stop_test();
		end
		@(posedge sys_clk);
	endtask

	task automatic host_op(input logic [31:0] ctrl);
		int n;
		n = 0;
		bus(1'b1, OFS_MEM_CTRL, ctrl);
		do begin
			bus(1'b0, OFS_STATUS, 32'h0);
			n++;
		end while (q[14] !== 1'b0 && n < 50);
		bus(1'b0, OFS_MEM_DATA, 32'h0);
	endtask

	function automatic logic in_span(input logic [12:0] got, input logic [12:0] base, input int lo, input int hi);
		logic [12:0] d;
		d = got - base;
		return d >= lo && d <= hi;
	endfunction

	task automatic pulse(input logic trunk);
		bus_frame <= !trunk;
		trunk_frame <= trunk;
		repeat (3) @(posedge sys_clk);
		bus_frame <= 1'b0;
		trunk_frame <= 1'b0;
		repeat (8) @(posedge sys_clk);
		bus(1'b0, OFS_STATUS, 32'h0);
	endtask

	// *****
	// Main sequence
	// *****
	initial begin
		void'($urandom(5));
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		bus(1'b0, OFS_LOCAL_STREAM_CONFIG, 32'h0);
		check_word(q, {24'h0, LSC_RESET});
		bus(1'b0, 8'h1C, 32'h0);
		check_word(q, 32'h0);
		en_rand <= 1'b1;
		for (int i = 0; i < 24; i++) begin
			v = (i < 4) ? {24'h0, {4{i[1:0]}}} : $urandom;
			bus(1'b1, OFS_LOCAL_STREAM_CONFIG, v);
			bus(1'b0, OFS_LOCAL_STREAM_CONFIG, 32'h0);
			check_word(q, {24'h0, v[7:0]});
		end
		en_rand <= 1'b0;
		for (int k = 0; k < 3; k++) begin
			v = (k == 0) ? 32'h1FFE : $urandom_range(8191);
			bus(1'b1, OFS_DIAG_LOAD, v);
			bus(1'b1, OFS_DIAG_CTRL, 32'h2);
			repeat (16) @(posedge sys_clk);
			bus(1'b0, OFS_STATUS, 32'h0);
			check_word({31'h0, in_span(q[12:0], v[12:0], 4, 9)}, 32'h1);
		end
		bus(1'b1, OFS_DIAG_CTRL, 32'h1);
		bus(1'b0, OFS_STATUS, 32'h0);
		check_word({31'h0, in_span(q[12:0], 13'h0, 0, 3)}, 32'h1);
		v = 32'h1000;
		bus(1'b1, OFS_DIAG_LOAD, v);
		bus(1'b1, OFS_DIAG_CTRL, 32'h6);
		pulse(1'b0);
		check_word({31'h0, in_span(q[12:0], v[12:0], 2, 12)}, 32'h1);
		pulse(1'b1);
		check_word({31'h0, in_span(q[12:0], 13'h0, 0, 6)}, 32'h1);
		bus(1'b1, OFS_LOCAL_STREAM_CONFIG, 32'h30);
		bus(1'b1, OFS_MEM_ADDR, 32'h0205);
		bus(1'b1, OFS_MEM_DATA, 32'h805);
		host_op(32'h2);
		bus(1'b1, OFS_DIAG_CTRL, 32'h1);
		for (int n = 0; n < 2000 && count < 13'h180; n++) begin
			@(posedge sys_clk);
		end
		check_word({24'h0, seen}, 32'hA0);
		check_word(others, 32'h0);
		bus(1'b0, OFS_STATUS, 32'h0);
		v = q;
		bus(1'b1, OFS_MEM_ADDR, 32'h0005);
		host_op({29'h0, v[13], 2'b01});
		check_word({24'h0, q[7:0]}, 32'hA0);
		bus(1'b1, OFS_MEM_ADDR, 32'h0205);
		host_op(32'h0);
		check_word({20'h0, q[11:0]}, 32'h805);
		stop_test();
	end
endmodule
